// [pkg/core_timer_pkg.sv]
// Purpose: constants and types shared by the core timer block
// Assumes: register indices are word indices, byte address = 4 * index
// Notes:   counts are in bus clock cycles
package core_timer_pkg;

    // register word indices
    localparam logic [15:0] IDX_STATUS_CONTROL = 16'h0008;
    localparam logic [15:0] IDX_COUNT          = 16'h0009;
    localparam logic [15:0] IDX_OPTION         = 16'h001d;
    localparam logic [15:0] IDX_SERVICE        = 16'h3ff0;
    localparam logic [15:0] IDX_EVT_STATUS     = 16'h0020;
    localparam logic [15:0] IDX_EVT_MASK       = 16'h0021;

    // reset vector fetched after a watchdog reset
    localparam logic [15:0] RESET_VECTOR_HI    = 16'h3ffe;
    localparam logic [15:0] RESET_VECTOR_LO    = 16'h3fff;

    // status and control, option, service and event field positions
    localparam int BIT_OVF_FLAG   = 7;
    localparam int BIT_TICK_FLAG  = 6;
    localparam int BIT_OVF_IE     = 5;
    localparam int BIT_TICK_IE    = 4;
    localparam int BIT_RATE_HI    = 1;
    localparam int BIT_RATE_LO    = 0;
    localparam int BIT_WDOG_EN    = 6;
    localparam int BIT_SERVICE    = 0;
    localparam int EVT_OVF        = 0;
    localparam int EVT_TICK       = 1;

    // reset values
    localparam logic [1:0] RATE_RESET     = 2'h3;
    localparam logic [1:0] EVT_MASK_RESET = 2'h0;

    // chain layout: prescaler [1:0], counter [9:2], extra [13:10], tick stages [16:14]
    localparam int CHAIN_W     = 17;
    localparam int COUNT_LSB   = 2;
    localparam int COUNT_MSB   = 9;
    localparam int OVF_MSB     = 9;
    localparam logic [CHAIN_W-1:0] CHAIN_ONE  = 17'h0_0001;
    localparam logic [CHAIN_W-1:0] CHAIN_FULL = 17'h1_ffff;
    localparam logic [1:0]         RATE_TOP   = 2'h3;

    // power-on sequence length
    localparam int          POR_CYCLES = 4064;
    localparam logic [11:0] POR_LAST   = 12'(POR_CYCLES - 1);

    // watchdog time-out in selected ticks
    localparam int         WDOG_TICKS = 7;
    localparam logic [2:0] WDOG_LAST  = 3'(WDOG_TICKS - 1);

    typedef enum logic {PH_POR, PH_RUN} phase_t;

endpackage

// [design/core_timer.sv]
// Purpose: core timer with overflow, periodic tick and watchdog, classic Wishbone slave
// Assumes: rst_i is power-on reset; ext_reset_i is the external reset pin
// Notes:   all state lives in one packed struct
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps

module core_timer
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // external reset pin
    input  wire logic        ext_reset_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // cpu side
    input  wire logic        stop_req_i,
    output logic             stop_ack_o,
    output logic             irq_o,
    output logic             wdog_reset_o,
    output logic             por_busy_o,
    output logic      [15:0] reset_vector_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        core_timer_pkg::phase_t          phase;
        logic [core_timer_pkg::CHAIN_W-1:0] chain;
        logic                            ovf_flag;
        logic                            tick_flag;
        logic                            ovf_ie;
        logic                            tick_ie;
        logic [1:0]                      rate;
        logic                            wdog_en;
        logic [2:0]                      wdog_cnt;
        logic                            wdog_rst;
        logic [1:0]                      evt_status;
        logic [1:0]                      evt_mask;
        logic                            ext_meta;
        logic                            ext_sync;
        logic                            ack;
        logic [31:0]                     rdata;
    } state_t;

    localparam state_t STATE_RESET = '{
        phase:      core_timer_pkg::PH_POR,
        chain:      '0,
        ovf_flag:   1'b0,
        tick_flag:  1'b0,
        ovf_ie:     1'b0,
        tick_ie:    1'b0,
        rate:       core_timer_pkg::RATE_RESET,
        wdog_en:    1'b1,
        wdog_cnt:   3'h0,
        wdog_rst:   1'b0,
        evt_status: 2'h0,
        evt_mask:   core_timer_pkg::EVT_MASK_RESET,
        ext_meta:   1'b0,
        ext_sync:   1'b0,
        ack:        1'b0,
        rdata:      32'h0000_0000
    };

    state_t q;
    state_t d;

    logic [15:0]                         idx;
    logic                                acc;
    logic                                wr_lane0;
    logic                                rd;
    logic                                running;
    logic                                ovf_evt;
    logic                                tick_evt;
    logic                                service_wr;
    logic                                timeout;
    logic [core_timer_pkg::CHAIN_W-1:0]  tick_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // decode and events

    assign idx        = wb_adr_i[17:2];
    assign acc        = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr_lane0   = acc & wb_we_i & wb_sel_i[0];
    assign rd         = acc & ~wb_we_i;
    assign running    = (q.phase == core_timer_pkg::PH_RUN) & ~q.ext_sync;
    assign ovf_evt    = running & (&q.chain[core_timer_pkg::OVF_MSB:0]);
    // tick when the low 14 + rate bits are all ones
    assign tick_mask  = core_timer_pkg::CHAIN_FULL >> (core_timer_pkg::RATE_TOP - q.rate);
    assign tick_evt   = running & (&(q.chain | ~tick_mask));
    assign service_wr = wr_lane0 & running & (idx == core_timer_pkg::IDX_SERVICE)
                        & ~wb_dat_i[core_timer_pkg::BIT_SERVICE];
    assign timeout    = q.wdog_en & tick_evt & ~service_wr
                        & (q.wdog_cnt == core_timer_pkg::WDOG_LAST);

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d          = q;
        d.ack      = acc;
        d.ext_meta = ext_reset_i;
        d.ext_sync = q.ext_meta;
        d.wdog_rst = 1'b0;

        // register reads, event status read clears sticky events
        if (rd)
        begin
            d.rdata = 32'h0000_0000;
            if (idx == core_timer_pkg::IDX_STATUS_CONTROL)
            begin
                d.rdata[core_timer_pkg::BIT_OVF_FLAG]  = q.ovf_flag;
                d.rdata[core_timer_pkg::BIT_TICK_FLAG] = q.tick_flag;
                d.rdata[core_timer_pkg::BIT_OVF_IE]    = q.ovf_ie;
                d.rdata[core_timer_pkg::BIT_TICK_IE]   = q.tick_ie;
                d.rdata[core_timer_pkg::BIT_RATE_HI:core_timer_pkg::BIT_RATE_LO] = q.rate;
            end
            else if (idx == core_timer_pkg::IDX_COUNT)
            begin
                d.rdata[7:0] = q.chain[core_timer_pkg::COUNT_MSB:core_timer_pkg::COUNT_LSB];
            end
            else if (idx == core_timer_pkg::IDX_OPTION)
            begin
                d.rdata[core_timer_pkg::BIT_WDOG_EN] = q.wdog_en;
            end
            else if (idx == core_timer_pkg::IDX_EVT_STATUS)
            begin
                d.rdata[1:0] = q.evt_status;
                d.evt_status = 2'h0;
            end
            else if (idx == core_timer_pkg::IDX_EVT_MASK)
            begin
                d.rdata[1:0] = q.evt_mask;
            end
        end

        // register writes
        if (wr_lane0 && running)
        begin
            if (idx == core_timer_pkg::IDX_STATUS_CONTROL)
            begin
                if (!wb_dat_i[core_timer_pkg::BIT_OVF_FLAG])
                begin
                    d.ovf_flag = 1'b0;
                end
                if (!wb_dat_i[core_timer_pkg::BIT_TICK_FLAG])
                begin
                    d.tick_flag = 1'b0;
                end
                d.ovf_ie  = wb_dat_i[core_timer_pkg::BIT_OVF_IE];
                d.tick_ie = wb_dat_i[core_timer_pkg::BIT_TICK_IE];
                d.rate    = wb_dat_i[core_timer_pkg::BIT_RATE_HI:core_timer_pkg::BIT_RATE_LO];
            end
            else if (idx == core_timer_pkg::IDX_OPTION)
            begin
                if (!wb_dat_i[core_timer_pkg::BIT_WDOG_EN])
                begin
                    d.wdog_en = 1'b0;
                end
            end
            else if (idx == core_timer_pkg::IDX_EVT_MASK)
            begin
                d.evt_mask = wb_dat_i[1:0];
            end
        end

        // counter chain
        case (q.phase)
            core_timer_pkg::PH_POR:
            begin
                if (q.chain[11:0] == core_timer_pkg::POR_LAST)
                begin
                    d.chain = '0;
                    d.phase = core_timer_pkg::PH_RUN;
                end
                else
                begin
                    d.chain = q.chain + core_timer_pkg::CHAIN_ONE;
                end
            end
            default:
            begin
                d.chain = q.chain + core_timer_pkg::CHAIN_ONE;
            end
        endcase

        // events set after clears so a set wins
        if (ovf_evt)
        begin
            d.ovf_flag                           = 1'b1;
            d.evt_status[core_timer_pkg::EVT_OVF] = 1'b1;
        end
        if (tick_evt)
        begin
            d.tick_flag                           = 1'b1;
            d.evt_status[core_timer_pkg::EVT_TICK] = 1'b1;
        end

        // watchdog divider
        if (service_wr)
        begin
            d.wdog_cnt = 3'h0;
        end
        else if (tick_evt && q.wdog_en)
        begin
            d.wdog_cnt = q.wdog_cnt + 3'h1;
        end

        // external or watchdog reset restores reset values of the timer fields; evt_status, phase, ack, rdata and the ext sync stages are left alone
        if (q.ext_sync || timeout)
        begin
            d.chain     = '0;
            d.ovf_flag  = 1'b0;
            d.tick_flag = 1'b0;
            d.ovf_ie    = 1'b0;
            d.tick_ie   = 1'b0;
            d.rate      = core_timer_pkg::RATE_RESET;
            d.wdog_en   = 1'b1;
            d.wdog_cnt  = 3'h0;
            d.evt_mask  = core_timer_pkg::EVT_MASK_RESET;
            d.wdog_rst  = timeout;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= STATE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_dat_o       = q.rdata;
    assign wb_ack_o       = q.ack;
    assign stop_ack_o     = stop_req_i & ~q.wdog_en;
    assign irq_o          = (q.ovf_flag & q.ovf_ie) | (q.tick_flag & q.tick_ie)
                            | (|(q.evt_status & q.evt_mask));
    assign wdog_reset_o   = q.wdog_rst;
    assign por_busy_o     = (q.phase == core_timer_pkg::PH_POR);
    assign reset_vector_o = core_timer_pkg::RESET_VECTOR_HI;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic plain_run;
    assign plain_run = running & ~timeout;

    sequence s_timeout_pulse;
        wdog_reset_o ##1 !wdog_reset_o;
    endsequence

    sequence s_chain_cleared;
        (q.chain == '0) && q.wdog_en;
    endsequence

    a_chain_step: assert property (plain_run |=> q.chain == $past(q.chain) + core_timer_pkg::CHAIN_ONE)
        else $error("chain did not advance by one");

    a_count_read: assert property (rd && idx == core_timer_pkg::IDX_COUNT
        |=> wb_ack_o && wb_dat_o[7:0] == $past(q.chain[9:2]) && wb_dat_o[31:8] == 24'h00_0000)
        else $error("count read returned wrong value");

    a_ovf_wrap: assert property (plain_run && ovf_evt |=> q.chain[9:0] == 10'h000)
        else $error("overflow not at counter wrap");

    a_ovf_flag_set: assert property (plain_run && ovf_evt |=> q.ovf_flag && (!q.ovf_ie || irq_o))
        else $error("overflow flag or request missing");

    a_flag_holds: assert property (q.tick_flag && !q.ext_sync && !timeout
        && !(wr_lane0 && idx == core_timer_pkg::IDX_STATUS_CONTROL) |=> q.tick_flag)
        else $error("tick flag cleared without a write");

    a_tick_base: assert property (plain_run && tick_evt && q.rate == 2'h0 |=> q.chain[13:0] == 14'h0000)
        else $error("fastest tick not on 16384 boundary");

    a_tick_slow: assert property (plain_run && tick_evt && q.rate == 2'h3 |=> q.chain == '0)
        else $error("slowest tick not on full chain wrap");

    a_tick_flag_set: assert property (plain_run && tick_evt |=> q.tick_flag)
        else $error("tick flag not set");

    a_wdog_count: assert property (plain_run && tick_evt && q.wdog_en && !service_wr
        |=> q.wdog_cnt == $past(q.wdog_cnt) + 3'h1)
        else $error("watchdog divider missed a tick");

    a_wdog_timeout: assert property (timeout |=> s_timeout_pulse and s_chain_cleared)
        else $error("watchdog time-out did not reset");

    a_wdog_service: assert property (service_wr && !q.ext_sync |=> q.wdog_cnt == 3'h0 && !wdog_reset_o)
        else $error("service did not restart watchdog");

    a_wdog_sticky: assert property (!q.wdog_en && !q.ext_sync |=> !q.wdog_en)
        else $error("watchdog re-enabled without reset");

    a_stop_refused: assert property (q.wdog_en |-> !stop_ack_o)
        else $error("stop granted with watchdog on");

    a_por_release: assert property (q.phase == core_timer_pkg::PH_POR
        && q.chain[11:0] == core_timer_pkg::POR_LAST |=> !por_busy_o && q.chain == '0)
        else $error("power-on release wrong");

    a_ext_clear: assert property (q.ext_sync |=> q.chain == '0 && !q.ovf_flag)
        else $error("external reset did not clear chain");

endmodule

// [bench/core_timer_tb_top.sv]
// Purpose: self-checking bench for the core timer over classic Wishbone
// Assumes: register indices and values from core_timer_pkg
// Notes:   stop request held high throughout; one tick rate is timed
`timescale 1ns/1ps

module core_timer_tb_top;

    ////////////////////////////////////////////////////////////////////////////////
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        ext_reset_i = 1'b0;
    logic        wb_cyc_i    = 1'b0;
    logic        wb_stb_i    = 1'b0;
    logic        wb_we_i     = 1'b0;
    logic [17:0] wb_adr_i    = 18'h0_0000;
    logic [3:0]  wb_sel_i    = 4'h1;
    logic [31:0] wb_dat_i    = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        stop_req_i  = 1'b1;
    logic        stop_ack_o;
    logic        irq_o;
    logic        wdog_reset_o;
    logic        por_busy_o;
    logic [15:0] reset_vector_o;
    int          n_mismatch  = 0;
    int          num_checks  = 0;
    int          cycle_n     = 0;
    int          t0;
    int          t1;
    int          ts;
    logic [31:0] rd;
    logic [7:0]  c0;

    ////////////////////////////////////////////////////////////////////////////////
    core_timer dut
    (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ext_reset_i    (ext_reset_i),
        .wb_cyc_i       (wb_cyc_i),
        .wb_stb_i       (wb_stb_i),
        .wb_we_i        (wb_we_i),
        .wb_adr_i       (wb_adr_i),
        .wb_sel_i       (wb_sel_i),
        .wb_dat_i       (wb_dat_i),
        .wb_dat_o       (wb_dat_o),
        .wb_ack_o       (wb_ack_o),
        .stop_req_i     (stop_req_i),
        .stop_ack_o     (stop_ack_o),
        .irq_o          (irq_o),
        .wdog_reset_o   (wdog_reset_o),
        .por_busy_o     (por_busy_o),
        .reset_vector_o (reset_vector_o)
    );

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i) cycle_n <= cycle_n + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb_access(input logic we, input logic [15:0] idx, input logic [31:0] wdat,
                             output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wdat;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16)
            check("wb_ack", 32'h0000_0000, 32'h0000_0001);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        wb_access(1'b1, idx, d, unused);
    endtask

    task automatic rdchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        wb_access(1'b0, idx, 32'h0000_0000, v);
        check(name, v, exp);
    endtask

    // bounded wait for the interrupt line, returns the cycle seen
    task automatic wait_irq(input int bound, output int t);
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < bound)
        begin
            @(posedge clk_i);
            n++;
        end
        check("irq_wait", 32'(irq_o), 32'h0000_0001);
        t = cycle_n;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t0 = cycle_n;
        while (por_busy_o !== 1'b0 && cycle_n - t0 < 5000) @(posedge clk_i);
        check("por_len", 32'(cycle_n - t0 >= 4064 && cycle_n - t0 <= 4068), 32'h0000_0001);
        rdchk("count_start", core_timer_pkg::IDX_COUNT, 32'h0000_0000);
        rdchk("status_rst", core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_0003);
        rdchk("option_rst", core_timer_pkg::IDX_OPTION, 32'h0000_0040);
        rdchk("mask_rst", core_timer_pkg::IDX_EVT_MASK, 32'h0000_0000);
        rdchk("unmapped", 16'h0030, 32'h0000_0000);
        check("vector", 32'(reset_vector_o), 32'h0000_3ffe);
        check("stop_refused", 32'(stop_ack_o), 32'h0000_0000);
        // count step over 400 cycles with an ignored write between
        wb_access(1'b0, core_timer_pkg::IDX_COUNT, 32'h0000_0000, rd);
        c0 = rd[7:0];
        wr(core_timer_pkg::IDX_COUNT, 32'h0000_00ff);
        repeat (394) @(posedge clk_i);
        wb_access(1'b0, core_timer_pkg::IDX_COUNT, 32'h0000_0000, rd);
        check("count_step", 32'(8'(rd[7:0] - c0)), 32'h0000_0064);
        // sticky event, masked interrupt, read clear
        wr(core_timer_pkg::IDX_EVT_MASK, 32'h0000_0001);
        wait_irq(1100, t0);
        rdchk("evt_status", core_timer_pkg::IDX_EVT_STATUS, 32'h0000_0001);
        check("irq_no_enable", 32'(irq_o), 32'h0000_0000);
        rdchk("evt_cleared", core_timer_pkg::IDX_EVT_STATUS, 32'h0000_0000);
        wr(core_timer_pkg::IDX_EVT_MASK, 32'h0000_0000);
        rdchk("ovf_flag", core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_0083);
        // overflow interrupt, write-one keeps, write-zero clears
        wr(core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_00e3);
        check("ovf_irq", 32'(irq_o), 32'h0000_0001);
        wr(core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_0023);
        check("ovf_clear", 32'(irq_o), 32'h0000_0000);
        wait_irq(1100, t0);
        wr(core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_0023);
        wait_irq(1100, t1);
        check("ovf_period", 32'(t1 - t0), 32'h0000_0400);
        // fastest tick rate, then let the watchdog run out
        wr(core_timer_pkg::IDX_SERVICE, 32'h0000_0000);
        wr(core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_00d0);
        ts = cycle_n;
        wait_irq(16500, t0);
        rdchk("tick_flag", core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_00d0);
        wr(core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_0090);
        check("tick_clear", 32'(irq_o), 32'h0000_0000);
        wait_irq(16500, t1);
        check("tick_period", 32'(t1 - t0), 32'h0000_4000);
        rdchk("evt_both", core_timer_pkg::IDX_EVT_STATUS, 32'h0000_0003);
        while (wdog_reset_o !== 1'b1 && cycle_n - ts < 7 * 16384 + 16) @(posedge clk_i);
        check("wdog_pulse", 32'(wdog_reset_o), 32'h0000_0001);
        check("wdog_time", 32'(cycle_n - ts > 6 * 16384), 32'h0000_0001);
        rdchk("ctl_after_wdog", core_timer_pkg::IDX_STATUS_CONTROL, 32'h0000_0003);
        rdchk("wdog_rearmed", core_timer_pkg::IDX_OPTION, 32'h0000_0040);
        // disable is one-way until a reset
        wr(core_timer_pkg::IDX_OPTION, 32'h0000_0000);
        check("stop_taken", 32'(stop_ack_o), 32'h0000_0001);
        wr(core_timer_pkg::IDX_OPTION, 32'h0000_0040);
        rdchk("wdog_stays_off", core_timer_pkg::IDX_OPTION, 32'h0000_0000);
        // external reset clears the chain and re-enables the watchdog
        ext_reset_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        ext_reset_i <= 1'b0;
        rdchk("count_ext", core_timer_pkg::IDX_COUNT, 32'h0000_0000);
        rdchk("wdog_back", core_timer_pkg::IDX_OPTION, 32'h0000_0040);
        check("stop_refused2", 32'(stop_ack_o), 32'h0000_0000);
        conclude();
    end

    // hang guard, well past the longest expected run
    initial
    begin
        #(100 * 200000);
        check("run_time", 32'h0000_0000, 32'h0000_0001);
        conclude();
    end

endmodule
